// file: rtl/exec_core.sv
// Execute core: decodes one instruction, updates accumulator, flags, file and stack
`default_nettype none
// How it works
// RQ1: 7-bit file address; destination bit selects target
// RQ2: Increment file, zero flag only
// RQ3: OR accumulator with file, zero flag only
// RQ4: Copy file to destination, updates zero
// RQ5: Store accumulator to file, flags unchanged
// RQ6: Load literal into accumulator, flags unchanged
// RQ7: Interrupt return pops stack, sets global enable
// RQ8: Return with literal, pops stack, two cycles
// RQ9: Subroutine return pops stack over two cycles
// RQ10: Rotate left through carry, carry only
// RQ11: Rotate right through carry, carry only
// RQ12: Sleep clears watchdog, sets time-out, clears power-down
// RQ13: Literal minus accumulator with carry, digit carry
// RQ14: File minus accumulator routed by destination
// RQ15: Nibble exchange, flags unchanged
// RQ16: XOR accumulator with file, zero flag only
// RQ17: XOR literal into accumulator, zero only
// RQ18: Sleep ends on reset, watchdog or interrupt
// RQ19: Program counter changes take two cycles
// RQ20: Zero flag set when result is zero
// RQ21: Rotate moves old carry into vacated bit
module exec_core
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                reset,
    // Instruction issue
    input  wire logic [INSN_W-1:0]   insn,
    input  wire logic                insn_valid,
    // File register read port (same clock, combinational read)
    output logic      [ADDR_W-1:0]   file_addr,
    input  wire logic [DATA_W-1:0]   file_rdata,
    // File register write strobe
    output logic                     file_we,
    output logic      [ADDR_W-1:0]   file_waddr,
    output logic      [DATA_W-1:0]   file_wdata,
    // Return stack
    input  wire logic [PC_W-1:0]     stack_top,
    output logic                     stack_pop,
    output logic                     pc_load,
    output logic      [PC_W-1:0]     pc_value,
    // Sleep wake sources, from pins
    input  wire logic                wake_watchdog,
    input  wire logic                wake_irq,
    // Core state
    output logic      [DATA_W-1:0]   accum,
    output logic                     carry_flag,
    output logic                     digit_carry_flag,
    output logic                     zero_flag,
    output logic                     time_out_flag,
    output logic                     powerdown_flag,
    output logic                     global_irq_enable,
    output logic                     watchdog_clear,
    output logic                     osc_stopped,
    output logic                     busy
);
    import exec_pkg::*;

    // ==========================================================
    // Decode
    // ==========================================================
    wire logic [5:0]        opc      = insn[13:8];
    wire logic              dest     = insn[DEST_BIT];     // see RQ1
    wire logic [ADDR_W-1:0] faddr    = insn[ADDR_W-1:0];   // see RQ1
    wire logic [7:0]        literal  = insn[7:0];
    op_kind_t               kind;
    op_kind_t               alu_kind;

    // Byte ops match all six opcode bits; literal ops ignore don't-care bits
    always_comb begin
        kind = K_NONE;
        if (insn == OP_IRQ_RETURN_OP) begin
            kind = K_IRQ_RETURN_OP;
        end else if (insn == OP_RETURN) begin
            kind = K_RETURN;
        end else if (insn == OP_SLEEP) begin
            kind = K_SLEEP;
        end else if ((opc & OP_MOVL_MASK) == OP_MOVL) begin
            kind = K_MOVL;
        end else if ((opc & OP_MOVL_MASK) == OP_RETL) begin
            kind = K_RETL;
        end else if ((opc & OP_SUBL_MASK) == OP_SUBL) begin
            kind = K_SUBL;
        end else if (opc == OP_XORL) begin
            kind = K_XORL;
        end else if (opc == OP_INCREMENT_FILE_OP) begin
            kind = K_INC;
        end else if (opc == OP_IOR) begin
            kind = K_IOR;
        end else if (opc == OP_COPY_FILE_OP) begin
            kind = K_COPY_FILE_OP;
        end else if (opc == OP_STORE_ACCUM_OP && dest) begin
            kind = K_STORE_ACCUM_OP;
        end else if (opc == OP_RL) begin
            kind = K_RL;
        end else if (opc == OP_RR) begin
            kind = K_RR;
        end else if (opc == OP_SUBF) begin
            kind = K_SUBF;
        end else if (opc == OP_SWAP) begin
            kind = K_SWAP;
        end else if (opc == OP_XORF) begin
            kind = K_XORF;
        end
    end

    // ==========================================================
    // Sequencer: run, second no-op cycle of a return, and sleep
    // ==========================================================
    typedef enum { S_RUN, S_NOP, S_SLEEP } seq_t;
    seq_t seq;
    seq_t next_seq;

    // Wake inputs come from outside the clock domain
    logic [1:0] wdt_sync;
    logic [1:0] irq_sync;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wdt_sync <= 2'b00;
            irq_sync <= 2'b00;
        end else begin
            wdt_sync <= {wdt_sync[0], wake_watchdog};
            irq_sync <= {irq_sync[0], wake_irq};
        end
    end
    wire logic wake = wdt_sync[1] | irq_sync[1];  // see RQ18 (reset wakes via reset)

    // Instructions are only taken in the run state
    wire logic take      = insn_valid && (seq == S_RUN);
    wire logic is_return = (kind == K_IRQ_RETURN_OP) || (kind == K_RETURN) || (kind == K_RETL);

    always_comb begin
        next_seq = seq;
        case (seq)
            S_RUN: begin
                if (take && is_return) begin
                    next_seq = S_NOP;      // see RQ19
                end else if (take && kind == K_SLEEP) begin
                    next_seq = S_SLEEP;    // see RQ12
                end
            end
            S_NOP:   next_seq = S_RUN;     // see RQ7 see RQ8 see RQ9
            S_SLEEP: begin
                if (wake) begin
                    next_seq = S_RUN;      // see RQ18
                end
            end
            default: next_seq = S_RUN;
        endcase
    end

    // ==========================================================
    // Datapath
    // ==========================================================
    assign alu_kind = take ? kind : K_NONE;

    logic [7:0] result;
    logic       c_new;
    logic       dc_new;
    logic       z_upd;
    logic       c_upd;
    logic       dc_upd;

    exec_alu u_alu (
        .kind      (alu_kind),
        .accum     (accum),
        .file_val  (file_rdata),
        .literal   (literal),
        .carry_in  (carry_flag),
        .result    (result),
        .carry_out (c_new),
        .dc_out    (dc_new),
        .z_upd     (z_upd),
        .c_upd     (c_upd),
        .dc_upd    (dc_upd)
    );

    // Destination routing
    wire logic file_kind  = (kind == K_INC) || (kind == K_IOR) || (kind == K_COPY_FILE_OP) ||
                            (kind == K_RL) || (kind == K_RR) || (kind == K_SUBF) ||
                            (kind == K_SWAP) || (kind == K_XORF);
    wire logic lit_kind   = (kind == K_MOVL) || (kind == K_RETL) ||
                            (kind == K_SUBL) || (kind == K_XORL);
    wire logic to_file    = take && ((file_kind && dest) || kind == K_STORE_ACCUM_OP);  // see RQ1 RQ5
    wire logic to_accum   = take && ((file_kind && !dest) || lit_kind);        // see RQ1
    wire logic next_zero  = (result == ZERO_BYTE);                             // see RQ20

    // Read address is driven straight from the instruction
    assign file_addr = faddr;

    // Accumulator and arithmetic flags
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            accum            <= ACCUM_RESET;
            carry_flag       <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag        <= 1'b0;
        end else begin
            if (to_accum) begin
                accum <= result;
            end
            if (c_upd) begin
                carry_flag <= c_new;       // see RQ10 see RQ11 see RQ13 see RQ14
            end
            if (dc_upd) begin
                digit_carry_flag <= dc_new;
            end
            if (z_upd) begin
                zero_flag <= next_zero;    // see RQ20
            end
        end
    end

    // File write strobe, one cycle per store
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            file_we    <= 1'b0;
            file_waddr <= '0;
            file_wdata <= ZERO_BYTE;
        end else begin
            file_we    <= to_file;         // see RQ1
            file_waddr <= faddr;
            file_wdata <= result;
        end
    end

    // Stack pop and program counter load on the second cycle of a return
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stack_pop <= 1'b0;
            pc_load   <= 1'b0;
            pc_value  <= '0;
        end else begin
            stack_pop <= take && is_return;  // see RQ7 see RQ8 see RQ9
            pc_load   <= take && is_return;
            pc_value  <= stack_top;
        end
    end

    // Power status, global enable, watchdog clear and oscillator stop
    // Time-out and power-down are active low status bits; reset leaves them set.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            time_out_flag     <= 1'b1;
            powerdown_flag    <= 1'b1;
            global_irq_enable <= 1'b0;
            watchdog_clear    <= 1'b0;
            osc_stopped       <= 1'b0;
            busy              <= 1'b0;
            seq               <= S_RUN;
        end else begin
            seq            <= next_seq;
            busy           <= (next_seq != S_RUN);
            watchdog_clear <= take && kind == K_SLEEP;        // see RQ12
            osc_stopped    <= (next_seq == S_SLEEP);          // see RQ12
            if (take && kind == K_SLEEP) begin
                time_out_flag  <= 1'b1;                       // see RQ12
                powerdown_flag <= 1'b0;
            end
            if (take && kind == K_IRQ_RETURN_OP) begin
                global_irq_enable <= 1'b1;                    // see RQ7
            end
        end
    end
endmodule // exec_core
`default_nettype wire

// file: rtl/exec_pkg.sv
// Package: opcodes, field positions, reset values and cycle counts of the execute core
`default_nettype none
package exec_pkg;
    // Instruction word layout (14 bits)
    localparam int          INSN_W        = 14;
    localparam int          DEST_BIT      = 7;
    localparam int          ADDR_W        = 7;
    localparam int          DATA_W        = 8;
    localparam int          GIE_BIT       = 7;
    localparam int          PC_W          = 13;
    // Byte-operation opcodes, bits 13..8
    localparam logic [5:0]  OP_INCREMENT_FILE_OP       = 6'h0A;
    localparam logic [5:0]  OP_IOR        = 6'h04;
    localparam logic [5:0]  OP_COPY_FILE_OP       = 6'h08;
    localparam logic [5:0]  OP_STORE_ACCUM_OP      = 6'h00;
    localparam logic [5:0]  OP_RL         = 6'h0D;
    localparam logic [5:0]  OP_RR         = 6'h0C;
    localparam logic [5:0]  OP_SUBF       = 6'h02;
    localparam logic [5:0]  OP_SWAP       = 6'h0E;
    localparam logic [5:0]  OP_XORF       = 6'h06;
    // Literal opcodes, bits 13..8 with don't-care bits masked
    localparam logic [5:0]  OP_MOVL       = 6'h30;
    localparam logic [5:0]  OP_MOVL_MASK  = 6'h3C;
    localparam logic [5:0]  OP_RETL       = 6'h34;
    localparam logic [5:0]  OP_SUBL       = 6'h3C;
    localparam logic [5:0]  OP_SUBL_MASK  = 6'h3E;
    localparam logic [5:0]  OP_XORL       = 6'h3A;
    // Full-word control opcodes
    localparam logic [13:0] OP_IRQ_RETURN_OP     = 14'h0009;
    localparam logic [13:0] OP_RETURN     = 14'h0008;
    localparam logic [13:0] OP_SLEEP      = 14'h0063;
    // Reset values
    localparam logic [7:0]  ACCUM_RESET   = 8'h00;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    // Cycles taken by an instruction that changes the program counter
    localparam int          BRANCH_CYCLES = 2;
    // Kind of operation decoded from the instruction word
    // Four-state base type, so the kind can travel on a net port
    typedef enum logic [4:0] {
        K_NONE, K_INC, K_IOR, K_COPY_FILE_OP, K_STORE_ACCUM_OP, K_RL, K_RR, K_SUBF, K_SWAP, K_XORF,
        K_MOVL, K_RETL, K_SUBL, K_XORL, K_IRQ_RETURN_OP, K_RETURN, K_SLEEP
    } op_kind_t;
endpackage
`default_nettype wire

// file: rtl/exec_alu.sv
// Combinational ALU of the execute core: result and flag updates per operation
`default_nettype none
module exec_alu
    import exec_pkg::*;
(
    // Operation and operands
    input  wire op_kind_t     kind,
    input  wire logic [7:0]   accum,
    input  wire logic [7:0]   file_val,
    input  wire logic [7:0]   literal,
    input  wire logic         carry_in,
    // Result and flags
    output logic       [7:0]  result,
    output logic              carry_out,
    output logic              dc_out,
    output logic              z_upd,
    output logic              c_upd,
    output logic              dc_upd
);
    import exec_pkg::*;

    // Subtraction as a + ~w + 1, so carry means no borrow
    wire logic [8:0] sub_f   = {1'b0, file_val} + {1'b0, ~accum} + 9'h001;
    wire logic [8:0] sub_l   = {1'b0, literal} + {1'b0, ~accum} + 9'h001;
    wire logic [4:0] sub_f_n = {1'b0, file_val[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;
    wire logic [4:0] sub_l_n = {1'b0, literal[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;

    // Result and flag selection
    always_comb begin
        result    = file_val;
        carry_out = carry_in;
        dc_out    = 1'b0;
        z_upd     = 1'b0;
        c_upd     = 1'b0;
        dc_upd    = 1'b0;
        case (kind)
            K_INC: begin
                result = file_val + 8'h01;  // see RQ2
                z_upd  = 1'b1;
            end
            K_IOR: begin
                result = accum | file_val;  // see RQ3
                z_upd  = 1'b1;
            end
            K_COPY_FILE_OP: begin
                result = file_val;          // see RQ4
                z_upd  = 1'b1;
            end
            K_STORE_ACCUM_OP: result = accum;        // see RQ5
            K_RL: begin
                result    = {file_val[6:0], carry_in};  // see RQ10 see RQ21
                carry_out = file_val[7];
                c_upd     = 1'b1;
            end
            K_RR: begin
                result    = {carry_in, file_val[7:1]};  // see RQ11 see RQ21
                carry_out = file_val[0];
                c_upd     = 1'b1;
            end
            K_SUBF: begin
                result    = sub_f[7:0];     // see RQ14
                carry_out = sub_f[8];
                dc_out    = sub_f_n[4];
                z_upd     = 1'b1;
                c_upd     = 1'b1;
                dc_upd    = 1'b1;
            end
            K_SWAP:   result = {file_val[3:0], file_val[7:4]};  // see RQ15
            K_XORF: begin
                result = accum ^ file_val;  // see RQ16
                z_upd  = 1'b1;
            end
            K_MOVL, K_RETL: result = literal;  // see RQ6 see RQ8
            K_SUBL: begin
                result    = sub_l[7:0];     // see RQ13
                carry_out = sub_l[8];
                dc_out    = sub_l_n[4];
                z_upd     = 1'b1;
                c_upd     = 1'b1;
                dc_upd    = 1'b1;
            end
            K_XORL: begin
                result = accum ^ literal;   // see RQ17
                z_upd  = 1'b1;
            end
            default: result = file_val;
        endcase
    end
endmodule // exec_alu
`default_nettype wire

// file: sim/exec_core_assertions.sv
// Port-level assertions for the execute core
`default_nettype none
module exec_core_assertions
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic                        clock,
    input wire logic                        reset,
    // Issue and file port
    input wire logic [exec_pkg::INSN_W-1:0] insn,
    input wire logic                        insn_valid,
    input wire logic [exec_pkg::DATA_W-1:0] file_rdata,
    input wire logic                        file_we,
    input wire logic [exec_pkg::ADDR_W-1:0] file_waddr,
    input wire logic [exec_pkg::DATA_W-1:0] file_wdata,
    // Stack and wake
    input wire logic [exec_pkg::PC_W-1:0]   stack_top,
    input wire logic                        stack_pop,
    input wire logic [exec_pkg::PC_W-1:0]   pc_value,
    input wire logic                        wake_watchdog,
    input wire logic                        wake_irq,
    // Core state
    input wire logic [exec_pkg::DATA_W-1:0] accum,
    input wire logic                        carry_flag,
    input wire logic                        zero_flag,
    input wire logic                        time_out_flag,
    input wire logic                        powerdown_flag,
    input wire logic                        watchdog_clear,
    input wire logic                        osc_stopped,
    input wire logic                        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    //==========================================================
    // Decode of the word on the edge that takes it
    wire logic       take = insn_valid && !busy;
    wire logic [5:0] opc  = insn[13:8];
    wire logic [6:0] fadr = insn[6:0];
    wire logic [7:0] lit  = insn[7:0];
    wire logic [1:0] cz   = {carry_flag, zero_flag};
    // Second cycle of a return: pop, target from the stack, stall
    sequence s_pop;
        stack_pop && busy && pc_value == $past(stack_top);
    endsequence
    //==========================================================
    // Properties
    a_store_write: assert property (
        take && opc == OP_STORE_ACCUM_OP && insn[DEST_BIT] |=> file_we
        && file_waddr == $past(fadr) && file_wdata == $past(accum))
        else $error("store did not reach the file");
    a_literal_load: assert property (
        take && (opc & OP_MOVL_MASK) == OP_MOVL |=> accum == $past(lit) && $stable(cz))
        else $error("literal load wrong");
    a_incr_zero: assert property (
        take && opc == OP_INCREMENT_FILE_OP && !insn[DEST_BIT] |=> accum == $past(file_rdata) + 8'h01
        && zero_flag == (accum == 8'h00) && $stable(carry_flag))
        else $error("increment wrong");
    a_rotate_left: assert property (
        take && opc == OP_RL && !insn[DEST_BIT]
        |=> {carry_flag, accum} == {$past(file_rdata), $past(carry_flag)})
        else $error("rotate left wrong");
    a_return_pop: assert property (
        take && insn == OP_RETURN |=> s_pop ##1 !busy && !stack_pop)
        else $error("return not two cycles");
    a_literal_return: assert property (
        take && (opc & OP_MOVL_MASK) == OP_RETL
        |=> s_pop and (accum == $past(lit) && $stable(cz)))
        else $error("literal return wrong");
    a_sleep_entry: assert property (
        take && insn == OP_SLEEP
        |=> !powerdown_flag && time_out_flag && watchdog_clear && osc_stopped)
        else $error("sleep entry wrong");
    a_sleep_hold: assert property (
        (osc_stopped && !wake_watchdog && !wake_irq) [*4] |=> osc_stopped)
        else $error("woke without a cause");
    a_wake_bound: assert property (
        osc_stopped && (wake_watchdog || wake_irq) |-> ##[1:4] !osc_stopped)
        else $error("wake too slow");
endmodule // exec_core_assertions
bind exec_core exec_core_assertions exec_core_assertions_i (
    .clock(clock), .reset(reset), .insn(insn), .insn_valid(insn_valid),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .stack_top(stack_top), .stack_pop(stack_pop),
    .pc_value(pc_value), .wake_watchdog(wake_watchdog), .wake_irq(wake_irq),
    .accum(accum), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .time_out_flag(time_out_flag), .powerdown_flag(powerdown_flag),
    .watchdog_clear(watchdog_clear), .osc_stopped(osc_stopped), .busy(busy)
);
`default_nettype wire

// file: sim/file_stack_model.sv
// File register space and return stack facing the execute core
`default_nettype none
module file_stack_model
    import exec_pkg::*;
(
    // Clock
    input  wire logic                        clock,
    // File register port
    input  wire logic [exec_pkg::ADDR_W-1:0] file_addr,
    output logic      [exec_pkg::DATA_W-1:0] file_rdata,
    input  wire logic                        file_we,
    input  wire logic [exec_pkg::ADDR_W-1:0] file_waddr,
    input  wire logic [exec_pkg::DATA_W-1:0] file_wdata,
    // Return stack
    input  wire logic                        stack_pop,
    output logic      [exec_pkg::PC_W-1:0]   stack_top
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [128];
    logic [2:0] depth = 3'h5;
    // Each entry carries its depth, so a missed pop shows as a wrong target
    assign file_rdata = mem[file_addr];
    assign stack_top  = {depth, 10'h155};
    // A write is seen by reads only after the edge, as in the real array
    always @(posedge clock) begin
        if (file_we) begin
            mem[file_waddr] <= file_wdata;
        end
        if (stack_pop) begin
            depth <= depth - 3'h1;
        end
    end
    // Defined contents from the start
    initial begin
        foreach (mem[j]) begin
            mem[j] = 8'h00;
        end
    end
endmodule // file_stack_model
`default_nettype wire

// file: sim/exec_core_tb.sv
// Self-checking bench for the execute core
`default_nettype none
module exec_core_tb import exec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    //==========================================================
    // Signals
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic              insn_valid = 1'b0;
    logic              wake_watchdog = 1'b0;
    logic              wake_irq = 1'b0;
    logic [INSN_W-1:0] insn = '0;
    logic [ADDR_W-1:0] file_addr, file_waddr;
    logic [DATA_W-1:0] file_rdata, file_wdata, accum;
    logic [PC_W-1:0]   stack_top, pc_value, exp_pc;
    logic              file_we, stack_pop, pc_load, carry_flag, digit_carry_flag, zero_flag;
    logic              time_out_flag, powerdown_flag, global_irq_enable, watchdog_clear;
    logic              osc_stopped, busy;
    logic [INSN_W-1:0] rets [3] = '{OP_RETURN, {OP_RETL, 8'hA5}, OP_IRQ_RETURN_OP};
    logic [DATA_W-1:0] ret_w [3] = '{8'h07, 8'hA5, 8'hA5};
    int                n_mismatch = 0;
    int                checks_done = 0;
    int                n;
    exec_core exec_core_i (
        .clock(clock), .reset(reset), .insn(insn), .insn_valid(insn_valid),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .stack_top(stack_top),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
        .wake_watchdog(wake_watchdog), .wake_irq(wake_irq), .accum(accum),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .time_out_flag(time_out_flag),
        .powerdown_flag(powerdown_flag), .global_irq_enable(global_irq_enable),
        .watchdog_clear(watchdog_clear), .osc_stopped(osc_stopped), .busy(busy)
    );
    file_stack_model file_stack_model_i (
        .clock(clock), .file_addr(file_addr), .file_rdata(file_rdata),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .stack_pop(stack_pop), .stack_top(stack_top)
    );
    always #10 clock = ~clock;
    //==========================================================
    // Tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Offer one word; hold keeps a decoy offered until the next word replaces it
    task automatic op(input logic [13:0] i, input logic hold);
        insn = i;
        insn_valid = 1'b1;
        @(posedge clock);
        #1;
        insn = {OP_MOVL, 8'h99};
        insn_valid = hold;
    endtask
    // Valid is left alone here, so a following op never writes it twice in one step
    task automatic gap();
        @(posedge clock);
        #1;
    endtask
    // The extra edge lets the registered file write land before checking
    task automatic t(input logic [13:0] i, input logic [7:0] w, input logic [2:0] f);
        op(i, 1'b0);
        gap();
        chk("accum", accum, w);
        chk("flags", {carry_flag, digit_carry_flag, zero_flag}, f);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // A hang counts as a failure
    initial begin
        #6000;
        n_mismatch++;
        results();
    end
    //==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge clock);
        #1;
        reset = 1'b0;
        chk("reset", {accum, time_out_flag, powerdown_flag, global_irq_enable}, 11'h006);
        t({OP_MOVL, 8'h5A}, 8'h5A, 3'b000);
        t({OP_STORE_ACCUM_OP, 1'b1, 7'h7F}, 8'h5A, 3'b000);
        chk("file 7F", file_stack_model_i.mem[7'h7F], 8'h5A);
        t({OP_INCREMENT_FILE_OP, 1'b0, 7'h7F}, 8'h5B, 3'b000);
        t({OP_MOVL, 8'hFF}, 8'hFF, 3'b000);
        t({OP_STORE_ACCUM_OP, 1'b1, 7'h10}, 8'hFF, 3'b000);
        t({OP_INCREMENT_FILE_OP, 1'b1, 7'h10}, 8'hFF, 3'b001);
        chk("file 10", file_stack_model_i.mem[7'h10], 8'h00);
        t({OP_MOVL, 8'h21}, 8'h21, 3'b001);
        t({OP_IOR, 1'b1, 7'h7F}, 8'h21, 3'b000);
        chk("file 7F", file_stack_model_i.mem[7'h7F], 8'h7B);
        t({OP_XORF, 1'b0, 7'h7F}, 8'h5A, 3'b000);
        t({OP_XORL, 8'h5A}, 8'h00, 3'b001);
        t({OP_COPY_FILE_OP, 1'b0, 7'h7F}, 8'h7B, 3'b000);
        t({OP_COPY_FILE_OP, 1'b1, 7'h10}, 8'h7B, 3'b001);
        t({OP_RL, 1'b0, 7'h7F}, 8'hF6, 3'b001);
        t({OP_STORE_ACCUM_OP, 1'b1, 7'h11}, 8'hF6, 3'b001);
        t({OP_RL, 1'b1, 7'h11}, 8'hF6, 3'b101);
        chk("file 11", file_stack_model_i.mem[7'h11], 8'hEC);
        t({OP_RR, 1'b0, 7'h11}, 8'hF6, 3'b001);
        t({OP_SUBL, 8'hF6}, 8'h00, 3'b111);
        t({OP_MOVL, 8'h13}, 8'h13, 3'b111);
        t({OP_SUBL, 8'h12}, 8'hFF, 3'b000);
        t({OP_MOVL, 8'h0B}, 8'h0B, 3'b000);
        t({OP_SUBF, 1'b1, 7'h7F}, 8'h0B, 3'b110);
        chk("file 7F", file_stack_model_i.mem[7'h7F], 8'h70);
        t({OP_SWAP, 1'b0, 7'h7F}, 8'h07, 3'b110);
        $display("test data operations done");
        // Returns, each with a decoy offered while the core stalls
        for (int k = 0; k < 3; k++) begin
            exp_pc = stack_top;
            op(rets[k], 1'b1);
            chk("return", {stack_pop, pc_load, busy, global_irq_enable}, {3'b111, k == 2});
            chk("return pc", 16'(pc_value), 16'(exp_pc));
            gap();
            chk("after return", {busy, stack_pop, accum, carry_flag, digit_carry_flag, zero_flag},
                {2'b00, ret_w[k], 3'b110});
        end
        $display("test returns done");
        // Sleep, then wake from each source in turn
        for (int k = 0; k < 2; k++) begin
            op(OP_SLEEP, 1'b0);
            chk("sleep", {powerdown_flag, time_out_flag, watchdog_clear, osc_stopped, busy},
                5'b01111);
            repeat (4) gap();
            chk("asleep", {watchdog_clear, osc_stopped, busy}, 3'b011);
            {wake_irq, wake_watchdog} = (k == 0) ? 2'b01 : 2'b10;
            n = 0;
            while (busy === 1'b1 && n < 8) begin
                gap();
                n++;
            end
            chk("wake delay", 16'(n), 16'h0003);
            {wake_irq, wake_watchdog} = 2'b00;
            repeat (3) gap();
        end
        $display("test sleep done");
        // External reset in mid-sleep also ends it
        op(OP_SLEEP, 1'b0);
        reset = 1'b1;
        gap();
        chk("reset in sleep", {osc_stopped, busy, accum, powerdown_flag}, 11'h001);
        reset = 1'b0;
        t({OP_MOVL, 8'h3C}, 8'h3C, 3'b000);
        $display("test reset wake done");
        results();
    end
endmodule // exec_core_tb
`default_nettype wire
